/* logger_pkg.sv */
package logger_pkg;

    // ------------------------------------------------------------
    // identity code
    // ------------------------------------------------------------
    localparam logic [7:0] family_code_default = 8'h5a; // arbitrary value
    localparam logic [47:0] serial_default = 48'h0123_4567_89ab; // arbitrary
    localparam int crc_data_bits = 56;
    localparam int crc_all_bits = 64;
    localparam logic [7:0] crc_poly_rev = 8'h8c;

    // ------------------------------------------------------------
    // identity and function commands
    // ------------------------------------------------------------
    localparam logic [7:0] cmd_read_id = 8'h33;
    localparam logic [7:0] cmd_match_id = 8'h55;
    localparam logic [7:0] cmd_search_id = 8'hf0;
    localparam logic [7:0] cmd_cond_search_id = 8'hec;
    localparam logic [7:0] cmd_skip_id = 8'hcc;
    localparam logic [7:0] cmd_fast_skip_id = 8'h3c;
    localparam logic [7:0] cmd_fast_match_id = 8'h69;
    localparam logic [7:0] cmd_resume_id = 8'ha5;

    localparam logic [7:0] cmd_write_buf = 8'h0f;
    localparam logic [7:0] cmd_read_buf = 8'haa;
    localparam logic [7:0] cmd_copy_buf = 8'h99;
    localparam logic [7:0] cmd_read_mem = 8'h69;
    localparam logic [7:0] cmd_clear_log = 8'h96;
    localparam logic [7:0] cmd_forced_conv = 8'h48;
    localparam logic [7:0] cmd_start_log = 8'hdd;
    localparam logic [7:0] cmd_battery = 8'h33;

    // ------------------------------------------------------------
    // result bytes
    // ------------------------------------------------------------
    localparam logic [7:0] res_busy = 8'hff;
    localparam logic [7:0] res_ok = 8'haa;
    localparam logic [7:0] res_ok_alt = 8'h55;
    localparam logic [7:0] res_mission = 8'h22;
    localparam logic [7:0] res_write_fail = 8'h44;
    localparam logic [7:0] res_bad_param = 8'h77;
    localparam logic [7:0] res_bad_auth = 8'h33;
    localparam logic [7:0] res_bad_pw = 8'h11;
    localparam logic [7:0] res_need_clear = 8'h00;

    // ------------------------------------------------------------
    // memory map
    // ------------------------------------------------------------
    localparam int addr_w = 17;
    localparam logic [16:0] gp_lo = 17'h00000;
    localparam logic [16:0] gp_hi = 17'h001ff;
    localparam logic [16:0] reg1_lo = 17'h00200;
    localparam logic [16:0] reg1_hi = 17'h0021f;
    localparam logic [16:0] reg2_lo = 17'h00220;
    localparam logic [16:0] reg2_hi = 17'h0023f;
    localparam logic [16:0] rsv1_lo = 17'h00240;
    localparam logic [16:0] rsv1_hi = 17'h0025f;
    localparam logic [16:0] bak1_lo = 17'h00260;
    localparam logic [16:0] bak1_hi = 17'h0027f;
    localparam logic [16:0] bak2_lo = 17'h00280;
    localparam logic [16:0] bak2_hi = 17'h0029f;
    localparam logic [16:0] rsv2_lo = 17'h002a0;
    localparam logic [16:0] rsv2_hi = 17'h00fff;
    localparam logic [16:0] log_lo = 17'h01000;
    localparam logic [16:0] log_hi = 17'h1f9ff;
    localparam int log_pages = 3920;
    localparam int page_bytes = 32;
    localparam int reg_bytes = 64;
    localparam int bak_bytes = 64;
    localparam logic [16:0] pw_read_lo = 17'h00228;
    localparam logic [16:0] pw_read_hi = 17'h0022f;
    localparam logic [16:0] pw_full_lo = 17'h00230;
    localparam logic [16:0] pw_full_hi = 17'h00237;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int clk_mhz = 200;
    localparam int clock_start_delay_ms = 2000;
    localparam longint clock_start_cycles =
        longint'(clock_start_delay_ms) * 1000 * clk_mhz;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        reg_none = 4'h0,
        reg_gp = 4'h1,
        reg_page = 4'h2,
        reg_backup = 4'h3,
        reg_log = 4'h4,
        reg_reserved = 4'h5
    } region_e;

    typedef struct packed {
        logic valid;
        logic [7:0] cmd;
        logic [16:0] addr;
        logic [7:0] end_status;
        logic [7:0] data;
    } func_req_s;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } byte_s;

endpackage

/* id_crc.sv */
module id_crc (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic clear_i,
    input wire logic shift_i,
    input wire logic bit_i,
    output logic [7:0] crc_o
);

    // ------------------------------------------------------------
    // crc shift register, lsb first, reflected feedback
    // ------------------------------------------------------------
    logic fb;
    assign fb = crc_o[0] ^ bit_i;

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            crc_o <= 8'h00;
        end else if (clear_i) begin
            crc_o <= 8'h00;
        end else if (shift_i) begin
            crc_o <= (crc_o >> 1) ^ (fb ? logger_pkg::crc_poly_rev : 8'h00);
        end
    end

endmodule

/* byte_mem.sv */
module byte_mem #(
    parameter int depth = 512,
    parameter int aw = 9
) (
    input wire logic mclk_i,
    input wire logic we_i,
    input wire logic [aw-1:0] waddr_i,
    input wire logic [7:0] wdata_i,
    input wire logic [aw-1:0] raddr_i,
    output logic [7:0] rdata_o
);

    // ------------------------------------------------------------
    // storage with registered read
    // ------------------------------------------------------------
    logic [7:0] mem [depth];

    always_ff @(posedge mclk_i) begin
        if (we_i) begin
            mem[waddr_i] <= wdata_i;
        end
        rdata_o <= mem[raddr_i];
    end

endmodule

/* logger_access.sv */
module logger_access #(
    parameter longint clock_start_cycles = logger_pkg::clock_start_cycles
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic bus_reset_i,
    input wire logic [7:0] family_i,
    input wire logic [47:0] serial_i,
    input wire logger_pkg::byte_s rx_i,
    input wire logger_pkg::func_req_s req_i,
    input wire logic mission_i,
    input wire logic pw_ok_i,
    input wire logic [7:0] log_data_i,
    output logic fast_mode_o,
    output logic func_ready_o,
    output logic id_bit_o,
    output logic crc_ok_o,
    output logger_pkg::byte_s tx_o,
    output logic [7:0] result_o,
    output logic cleared_o,
    output logic [16:0] log_addr_o
);

    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------
    function automatic logger_pkg::region_e region_of(logic [16:0] a);
        if (a <= logger_pkg::gp_hi) region_of = logger_pkg::reg_gp;
        else if (a >= logger_pkg::reg1_lo && a <= logger_pkg::reg2_hi)
            region_of = logger_pkg::reg_page;
        else if (a >= logger_pkg::bak1_lo && a <= logger_pkg::bak2_hi)
            region_of = logger_pkg::reg_backup;
        else if (a >= logger_pkg::log_lo && a <= logger_pkg::log_hi)
            region_of = logger_pkg::reg_log;
        else region_of = logger_pkg::reg_reserved;
    endfunction

    function automatic logic is_pw(logic [16:0] a);
        is_pw = (a >= logger_pkg::pw_read_lo && a <= logger_pkg::pw_full_hi);
    endfunction

    function automatic logic is_id_cmd(logic [7:0] c);
        case (c)
            logger_pkg::cmd_read_id, logger_pkg::cmd_match_id,
            logger_pkg::cmd_search_id, logger_pkg::cmd_cond_search_id,
            logger_pkg::cmd_skip_id, logger_pkg::cmd_fast_skip_id,
            logger_pkg::cmd_fast_match_id, logger_pkg::cmd_resume_id:
                is_id_cmd = 1'b1;
            default: is_id_cmd = 1'b0;
        endcase
    endfunction

    // ------------------------------------------------------------
    // identity phase
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        st_wait_id = 3'b001,
        st_send_id = 3'b010,
        st_func = 3'b100
    } phase_e;

    phase_e phase_r;
    logic [63:0] id_word;
    logic [6:0] id_cnt_r;
    logic crc_clear;
    logic crc_shift;
    logic [7:0] crc_val;
    assign id_word = {crc_val, serial_i, family_i};
    assign crc_clear = rx_i.valid && phase_r == st_wait_id;
    assign crc_shift = phase_r == st_send_id &&
        id_cnt_r < 7'(logger_pkg::crc_data_bits);

    id_crc u_crc (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .clear_i(crc_clear),
        .shift_i(crc_shift),
        .bit_i(id_word[id_cnt_r[5:0]]),
        .crc_o(crc_val)
    );

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            phase_r <= st_wait_id;
            id_cnt_r <= 7'h00;
            id_bit_o <= 1'b0;
        end else if (bus_reset_i) begin
            phase_r <= st_wait_id;
            id_cnt_r <= 7'h00;
        end else begin
            case (phase_r)
                st_wait_id: begin
                    if (rx_i.valid && is_id_cmd(rx_i.data)) begin
                        phase_r <= st_send_id;
                        id_cnt_r <= 7'h00;
                    end
                end
                st_send_id: begin
                    if (id_cnt_r < 7'(logger_pkg::crc_all_bits)) begin
                        id_bit_o <= id_word[id_cnt_r[5:0]];
                        id_cnt_r <= id_cnt_r + 7'h01;
                    end else begin
                        phase_r <= st_func;
                    end
                end
                st_func: phase_r <= st_func;
                default: phase_r <= st_wait_id;
            endcase
        end
    end

    // ------------------------------------------------------------
    // crc self check: crc over full code returns to zero
    // ------------------------------------------------------------
    logic [7:0] chk_r;
    logic [6:0] chk_cnt_r;
    logic chk_fb;
    assign chk_fb = chk_r[0] ^ id_word[chk_cnt_r[5:0]];
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            chk_r <= 8'h00;
            chk_cnt_r <= 7'h00;
            crc_ok_o <= 1'b0;
        end else if (phase_r == st_send_id &&
                     id_cnt_r == 7'(logger_pkg::crc_all_bits)) begin
            chk_r <= 8'h00;
            chk_cnt_r <= 7'h00;
        end else if (chk_cnt_r < 7'(logger_pkg::crc_all_bits)) begin
            chk_r <= (chk_r >> 1) ^
                (chk_fb ? logger_pkg::crc_poly_rev : 8'h00);
            chk_cnt_r <= chk_cnt_r + 7'h01;
        end else begin
            crc_ok_o <= (chk_r == 8'h00);
        end
    end

    // ------------------------------------------------------------
    // speed mode and function gate
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            fast_mode_o <= 1'b0;
        end else if (phase_r == st_wait_id && rx_i.valid &&
                     (rx_i.data == logger_pkg::cmd_fast_skip_id ||
                      rx_i.data == logger_pkg::cmd_fast_match_id)) begin
            fast_mode_o <= 1'b1;
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            func_ready_o <= 1'b0;
        end else begin
            func_ready_o <= (phase_r == st_func) && !bus_reset_i;
        end
    end

    // ------------------------------------------------------------
    // buffer page and general memory
    // ------------------------------------------------------------
    logic [7:0] buf_r [logger_pkg::page_bytes];
    logic [511:0] written_r;
    logic [7:0] regs_r [logger_pkg::reg_bytes];
    logic gp_we;
    logic [7:0] gp_rd;
    logic [4:0] copy_idx_r;
    logic copying_r;
    logic [16:0] copy_base_r;
    logic accept;
    logger_pkg::region_e req_reg;
    localparam logic [7:0] res_go = logger_pkg::res_busy;
    logic [7:0] copy_res;

    assign accept = req_i.valid && phase_r == st_func;
    assign req_reg = region_of(req_i.addr);
    assign gp_we = copying_r &&
        region_of(copy_base_r) == logger_pkg::reg_gp &&
        !written_r[copy_base_r[8:0] + 9'(copy_idx_r)];
    byte_mem #(
        .depth(512),
        .aw(9)
    ) u_gp (
        .mclk_i(mclk_i),
        .we_i(gp_we),
        .waddr_i(copy_base_r[8:0] + 9'(copy_idx_r)),
        .wdata_i(buf_r[copy_idx_r]),
        .raddr_i(req_i.addr[8:0]),
        .rdata_o(gp_rd)
    );

    always_ff @(posedge mclk_i) begin
        if (accept && req_i.cmd == logger_pkg::cmd_write_buf) begin
            buf_r[req_i.addr[4:0]] <= req_i.data;
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            copying_r <= 1'b0;
            copy_idx_r <= 5'h00;
            copy_base_r <= 17'h00000;
            written_r <= '0;
            for (int i = 0; i < logger_pkg::reg_bytes; i++) regs_r[i] <= 8'h00;
        end else if (accept && req_i.cmd == logger_pkg::cmd_clear_log) begin
            written_r <= '0;
        end else if (accept && req_i.cmd == logger_pkg::cmd_copy_buf &&
                     copy_res == res_go) begin
            copying_r <= 1'b1;
            copy_idx_r <= 5'h00;
            copy_base_r <= {req_i.addr[16:5], 5'h00};
        end else if (copying_r) begin
            if (gp_we) written_r[copy_base_r[8:0] + 9'(copy_idx_r)] <= 1'b1;
            if (region_of(copy_base_r) == logger_pkg::reg_page)
                regs_r[{copy_base_r[5], copy_idx_r}] <= buf_r[copy_idx_r];
            copy_idx_r <= copy_idx_r + 5'h01;
            copying_r <= (copy_idx_r != 5'h1f);
        end
    end

    // ------------------------------------------------------------
    // copy checks and result byte
    // ------------------------------------------------------------
    always_comb begin
        copy_res = res_go;
        if (!pw_ok_i) copy_res = logger_pkg::res_bad_pw;
        else if (req_i.end_status != 8'h1f || req_i.addr[4:0] != 5'h00)
            copy_res = logger_pkg::res_bad_auth;
        else if (req_reg == logger_pkg::reg_page && mission_i)
            copy_res = logger_pkg::res_mission;
        else if (req_reg != logger_pkg::reg_gp &&
                 req_reg != logger_pkg::reg_page)
            copy_res = logger_pkg::res_bad_param;
        else if (req_reg == logger_pkg::reg_gp &&
                 |written_r[req_i.addr[8:0] +: 32])
            copy_res = logger_pkg::res_need_clear;
    end

    // one-time clock start delay out of the cleared state
    logic [31:0] delay_cnt_r;
    logic ext_cmd;
    assign ext_cmd = req_i.cmd == logger_pkg::cmd_copy_buf ||
        req_i.cmd == logger_pkg::cmd_forced_conv ||
        req_i.cmd == logger_pkg::cmd_start_log ||
        req_i.cmd == logger_pkg::cmd_battery;
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            cleared_o <= 1'b1;
            delay_cnt_r <= 32'h0;
            result_o <= logger_pkg::res_busy;
        end else if (accept && req_i.cmd == logger_pkg::cmd_clear_log) begin
            cleared_o <= 1'b1;
            result_o <= mission_i ? logger_pkg::res_mission
                                  : logger_pkg::res_ok;
        end else if (accept && ext_cmd) begin
            if (req_i.cmd == logger_pkg::cmd_copy_buf && copy_res != res_go)
                result_o <= copy_res;
            else begin
                result_o <= logger_pkg::res_busy;
                delay_cnt_r <= cleared_o ? 32'(clock_start_cycles) : 32'h1;
                cleared_o <= 1'b0;
            end
        end else if (delay_cnt_r > 32'h1 && !copying_r) begin
            delay_cnt_r <= delay_cnt_r - 32'h1;
        end else if (delay_cnt_r == 32'h1 && !copying_r) begin
            delay_cnt_r <= 32'h0;
            result_o <= logger_pkg::res_ok;
        end
    end

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    logger_pkg::region_e rd_reg_r;
    logic rd_pw_r;
    logic [5:0] rd_idx_r;
    logic rd_buf_r;
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            rd_reg_r <= logger_pkg::reg_none;
            rd_pw_r <= 1'b0;
            rd_buf_r <= 1'b0;
            rd_idx_r <= 6'h00;
            log_addr_o <= 17'h00000;
        end else if (accept && (req_i.cmd == logger_pkg::cmd_read_mem ||
                     req_i.cmd == logger_pkg::cmd_read_buf)) begin
            rd_reg_r <= req_reg;
            rd_buf_r <= req_i.cmd == logger_pkg::cmd_read_buf;
            rd_pw_r <= is_pw(req_i.addr);
            rd_idx_r <= req_i.addr[5:0];
            log_addr_o <= req_i.addr - logger_pkg::log_lo;
        end else begin
            rd_reg_r <= logger_pkg::reg_none;
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            tx_o <= '0;
        end else begin
            tx_o.valid <= rd_reg_r != logger_pkg::reg_none;
            case (rd_reg_r)
                logger_pkg::reg_gp: tx_o.data <= gp_rd;
                logger_pkg::reg_page:
                    tx_o.data <= rd_pw_r ? 8'h00 : regs_r[rd_idx_r];
                logger_pkg::reg_log: tx_o.data <= log_data_i;
                default: tx_o.data <= 8'h00;
            endcase
            if (rd_buf_r) tx_o.data <= buf_r[rd_idx_r[4:0]];
        end
    end

endmodule

/* logger_access_monitor.sv */
module logger_access_monitor #(
    parameter longint clock_start_cycles = 20
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic bus_reset_i,
    input wire logic [7:0] family_i,
    input wire logic [47:0] serial_i,
    input wire logger_pkg::byte_s rx_i,
    input wire logger_pkg::func_req_s req_i,
    input wire logic mission_i,
    input wire logic pw_ok_i,
    input wire logic [7:0] log_data_i,
    input wire logic fast_mode_o,
    input wire logic func_ready_o,
    input wire logic id_bit_o,
    input wire logic crc_ok_o,
    input wire logger_pkg::byte_s tx_o,
    input wire logic [7:0] result_o,
    input wire logic cleared_o,
    input wire logic [16:0] log_addr_o
);
    // ------------------------------------------------------------
    // port checks
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (rst_i);
    logic is_copy;
    logic is_rd;
    logic rsv;
    logic pw;
    assign is_copy = func_ready_o && req_i.valid
        && req_i.cmd == logger_pkg::cmd_copy_buf;
    assign is_rd = func_ready_o && req_i.valid
        && req_i.cmd == logger_pkg::cmd_read_mem;
    assign rsv = (req_i.addr >= 17'h00240 && req_i.addr <= 17'h0025f)
        || (req_i.addr >= 17'h002a0 && req_i.addr <= 17'h00fff);
    assign pw = req_i.addr >= 17'h00228 && req_i.addr <= 17'h00237;
    reset_vals_a: assert property ($fell(rst_i) |-> result_o == 8'hff)
        else $error("result byte not idle after reset");
    fast_hold_a: assert property (fast_mode_o |=> fast_mode_o)
        else $error("fast mode dropped");
    fast_entry_a: assert property (!func_ready_o && rx_i.valid
        && rx_i.data == 8'h3c |-> ##[1:3] fast_mode_o)
        else $error("fast mode not entered");
    func_gate_a: assert property (!func_ready_o && req_i.valid
        |=> $stable(result_o) ##1 !tx_o.valid)
        else $error("request acted on before identity phase");
    phase_drop_a: assert property (bus_reset_i |=> !func_ready_o)
        else $error("function phase kept after link reset");
    bad_auth_a: assert property (is_copy && req_i.end_status != 8'h1f
        && pw_ok_i |=> result_o == 8'h33)
        else $error("bad end status not reported");
    mission_block_a: assert property (is_copy && mission_i && pw_ok_i
        && req_i.end_status == 8'h1f && req_i.addr[16:6] == 11'h008
        && req_i.addr[4:0] == 5'h00 |=> result_o == 8'h22)
        else $error("register page write not blocked");
    result_codes_a: assert property (result_o inside {8'hff, 8'haa,
        8'h55, 8'h22, 8'h44, 8'h77, 8'h33, 8'h11, 8'h00})
        else $error("undefined result byte");
    reserved_zero_a: assert property (is_rd && rsv
        |-> ##[1:3] tx_o.valid ##0 tx_o.data == 8'h00)
        else $error("reserved read not zero");
    pw_hidden_a: assert property (is_rd && pw
        |-> ##[1:3] tx_o.valid ##0 tx_o.data == 8'h00)
        else $error("password byte exposed");
    cover property (is_copy);
    cover property ($rose(fast_mode_o));
    cover property (is_rd && rsv);
endmodule

bind logger_access logger_access_monitor #(
    .clock_start_cycles(clock_start_cycles)
) mon (
    .mclk_i, .rst_i, .bus_reset_i, .family_i, .serial_i, .rx_i, .req_i,
    .mission_i, .pw_ok_i, .log_data_i, .fast_mode_o, .func_ready_o,
    .id_bit_o, .crc_ok_o, .tx_o, .result_o, .cleared_o, .log_addr_o
);

/* link_host.sv */
module link_host (
    input wire logic mclk_i,
    output logic bus_reset_o,
    output logger_pkg::byte_s rx_o,
    output logger_pkg::func_req_s req_o
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        bus_reset_o = 1'b0;
        rx_o = '0;
        req_o = '0;
    end
    // ------------------------------------------------------------
    // link reset, then identity byte, before any function request
    // ------------------------------------------------------------
    task automatic start(input logic [7:0] id);
        @(posedge mclk_i);
        bus_reset_o <= 1'b1;
        @(posedge mclk_i);
        bus_reset_o <= 1'b0;
        rx_o <= '{1'b1, id};
        @(posedge mclk_i);
        rx_o <= '0;
    endtask
    task automatic send(input logic [7:0] cmd, input logic [16:0] a,
            input logic [7:0] es, input logic [7:0] d);
        @(posedge mclk_i);
        req_o <= '{1'b1, cmd, a, es, d};
        @(posedge mclk_i);
        req_o <= '0;
    endtask
endmodule

/* logger_access_bench.sv */
module logger_access_bench;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int delay_c = 20;
    logic mclk_i = 1'b0;
    logic rst_i = 1'b1;
    logic mission_i = 1'b0;
    logic pw_ok_i = 1'b1;
    logic [7:0] log_data_i = 8'h3e;
    logic [7:0] family_i = logger_pkg::family_code_default;
    logic [47:0] serial_i = logger_pkg::serial_default;
    logic bus_reset_i;
    logger_pkg::byte_s rx_i;
    logger_pkg::byte_s tx_o;
    logger_pkg::func_req_s req_i;
    logic fast_mode_o, func_ready_o, id_bit_o, crc_ok_o, cleared_o;
    logic [7:0] result_o;
    logic [16:0] log_addr_o;
    int err_total = 0;
    int n_tests = 0;
    int n;
    always #2.5 mclk_i = ~mclk_i;
    logger_access #(.clock_start_cycles(delay_c)) dut (
        .mclk_i, .rst_i, .bus_reset_i, .family_i, .serial_i, .rx_i, .req_i,
        .mission_i, .pw_ok_i, .log_data_i, .fast_mode_o, .func_ready_o,
        .id_bit_o, .crc_ok_o, .tx_o, .result_o, .cleared_o, .log_addr_o
    );
    link_host host (.mclk_i(mclk_i), .bus_reset_o(bus_reset_i),
        .rx_o(rx_i), .req_o(req_i));
    // ------------------------------------------------------------
    // helpers and scenarios
    // ------------------------------------------------------------
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run();
        $display("tests %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic rd(input logic [7:0] cmd, input logic [16:0] a,
            input logic [7:0] exp);
        int k;
        host.send(cmd, a, 8'h00, 8'h00);
        k = 0;
        #1;
        while (tx_o.valid !== 1'b1 && k < 4) begin
            @(posedge mclk_i);
            #1;
            k++;
        end
        check(tx_o.data, exp);
        check(k < 4, 1'b1);
        if (k == 4) complete_run();
    endtask
    task automatic copy(input logic [16:0] a, input logic [7:0] es,
            input logic m, input logic p, input logic [7:0] exp);
        @(posedge mclk_i);
        mission_i <= m;
        pw_ok_i <= p;
        host.send(logger_pkg::cmd_copy_buf, a, es, 8'h00);
        n = 0;
        #1;
        while (result_o === 8'hff && n < 200) begin
            @(posedge mclk_i);
            #1;
            n++;
        end
        check(result_o, exp);
        if (n == 200) complete_run();
    endtask
    task automatic gated();
        host.send(logger_pkg::cmd_copy_buf, 17'h0, 8'h1f, 8'h00);
        repeat (3) @(posedge mclk_i);
        #1;
        check(result_o, 8'hff);
        check(func_ready_o, 1'b0);
    endtask
    task automatic read_id();
        logic [63:0] code;
        logic [7:0] crc;
        code = {8'h00, serial_i, family_i};
        crc = 8'h00;
        for (int i = 0; i < 56; i++) begin
            crc = (crc >> 1) ^ ((crc[0] ^ code[i]) ? 8'h8c : 8'h00);
        end
        code[63:56] = crc;
        host.start(logger_pkg::cmd_read_id);
        @(posedge mclk_i);
        for (int i = 0; i < 64; i++) begin
            #1;
            check(id_bit_o, code[i]);
            @(posedge mclk_i);
        end
        repeat (66) @(posedge mclk_i);
        #1;
        check(crc_ok_o, 1'b1);
        check(func_ready_o, 1'b1);
        check(fast_mode_o, 1'b0);
    endtask
    task automatic buffer_fill();
        for (int i = 0; i < 32; i++) begin
            host.send(logger_pkg::cmd_write_buf, 17'(i), 8'h00, 8'ha0 + 8'(i));
        end
        rd(logger_pkg::cmd_read_buf, 17'h3, 8'ha3);
    endtask
    task automatic copies();
        copy(17'h00200, 8'h1f, 1'b1, 1'b1, 8'h22);
        copy(17'h00000, 8'h1e, 1'b0, 1'b1, 8'h33);
        copy(17'h00000, 8'h1f, 1'b0, 1'b0, 8'h11);
        copy(17'h00000, 8'h1f, 1'b0, 1'b1, 8'haa);
        check(n > 32 + delay_c / 2, 1'b1);
        check(cleared_o, 1'b0);
        copy(17'h00000, 8'h1f, 1'b0, 1'b1, 8'h00);
        copy(17'h00200, 8'h1f, 1'b0, 1'b1, 8'haa);
        check(n < 32 + delay_c / 2, 1'b1);
        copy(17'h00220, 8'h1f, 1'b0, 1'b1, 8'haa);
        host.send(logger_pkg::cmd_clear_log, 17'h0, 8'h00, 8'h00);
        #1;
        check(result_o, 8'haa);
        check(cleared_o, 1'b1);
        copy(17'h00000, 8'h1f, 1'b0, 1'b1, 8'haa);
        check(n > 32 + delay_c / 2, 1'b1);
    endtask
    task automatic reads();
        rd(logger_pkg::cmd_read_mem, 17'h00005, 8'ha5);
        rd(logger_pkg::cmd_read_mem, 17'h00206, 8'ha6);
        rd(logger_pkg::cmd_read_mem, 17'h00229, 8'h00);
        rd(logger_pkg::cmd_read_mem, 17'h00240, 8'h00);
        rd(logger_pkg::cmd_read_mem, 17'h002a3, 8'h00);
        rd(logger_pkg::cmd_read_mem, 17'h01007, 8'h3e);
        check(log_addr_o, 17'h00007);
    endtask
    task automatic fast();
        host.start(logger_pkg::cmd_fast_skip_id);
        repeat (3) @(posedge mclk_i);
        #1;
        check(fast_mode_o, 1'b1);
    endtask
    initial begin
        repeat (12) @(posedge mclk_i);
        rst_i <= 1'b0;
        @(posedge mclk_i);
        #1;
        check(result_o, 8'hff);
        check(cleared_o, 1'b1);
        gated();
        read_id();
        buffer_fill();
        copies();
        reads();
        fast();
        complete_run();
    end
endmodule
